// file: design/dbw_pkg.sv
// Purpose: Constants and carrier types for the downstream bridge header registers
// Assumes: Byte-addressed configuration access, one byte lane per strobe
// Notes:   Offsets are configuration space byte addresses
package dbw_pkg;
    localparam logic [7:0]  OFF_PRIMARY_BUS    = 8'h18;
    localparam logic [7:0]  OFF_SECONDARY_BUS  = 8'h19;
    localparam logic [7:0]  OFF_SUBORDINATE    = 8'h1a;
    localparam logic [7:0]  OFF_SEC_LATENCY    = 8'h1b;
    localparam logic [7:0]  OFF_IO_BOTTOM      = 8'h1c;
    localparam logic [7:0]  OFF_IO_TOP         = 8'h1d;
    localparam logic [7:0]  OFF_STATUS_LO      = 8'h1e;
    localparam logic [7:0]  OFF_STATUS_HI      = 8'h1f;
    localparam logic [7:0]  RST_BUS_NUMBER     = 8'h00;
    localparam logic [7:0]  RST_SEC_LATENCY    = 8'h00;
    localparam logic [3:0]  RST_IO_FIELD       = 4'h0;
    localparam logic [3:0]  IO_ADDRESSING_TYPE = 4'h1;
    localparam logic [15:0] RST_STATUS         = 16'h0000;
    localparam logic [7:0]  RST_RDATA          = 8'h00;
    localparam logic [11:0] IO_LOW_ZEROS       = 12'h000;
    localparam logic [11:0] IO_LOW_ONES        = 12'hfff;
    localparam int          ST_POISON          = 15;
    localparam int          ST_SYS_ERR         = 14;
    localparam int          ST_UR_RECEIVED     = 13;
    localparam int          ST_CA_RECEIVED     = 12;
    localparam int          ST_CA_SENT         = 11;
    localparam int          ST_MASTER_PAR      = 8;
    localparam logic [15:0] STATUS_W1C_MASK    = 16'hf900;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dbw_cfg_req_t;

    typedef struct packed {
        logic poisoned;
        logic sys_err;
        logic ur_cpl;
        logic ca_cpl;
        logic ca_sent;
        logic master_par;
    } dbw_evt_t;
endpackage : dbw_pkg

// file: design/dbw_regs.sv
// Purpose: Bus numbers, I/O window and link-side status of a downstream bridge port
// Assumes: One byte access per cycle; read data returned one cycle after request
// Notes:   Events are one-cycle pulses from the link logic
//
// Contract
// - Primary bus number, 8-bit read/write, resets to zero
// - Secondary bus number, 8-bit read/write, resets zero, used for Type 1 decode
// - Subordinate bus number, 8-bit read/write, resets zero, bounds Type 1 decode
// - Secondary latency timer reads zero always
// - I/O bottom bits 7:4 writable, address 15:12, low twelve bits zero
// - I/O top bits 7:4 writable, address 15:12, low twelve bits ones
// - Low nibble of both I/O registers reads one, writes ignored
// - I/O window decides whether an I/O transaction is forwarded
// - Upper sixteen window bits come from separate registers, form 32-bit bounds
// - Sixteen-bit status, resets zero, hardware set, write one clears
// - Poisoned packet on link sets bit 15 regardless of parity enable
`timescale 1ns/1ps
module dbw_regs
    import dbw_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire dbw_cfg_req_t cfg_req_i,
    output logic [7:0]        cfg_rdata_o,
    output logic              cfg_rvalid_o,
    input  wire dbw_evt_t     evt_i,
    input  wire logic         parity_resp_en_i,
    input  wire logic [15:0]  io_bottom_upper_i,
    input  wire logic [15:0]  io_top_upper_i,
    input  wire logic         io_req_i,
    input  wire logic [31:0]  io_addr_i,
    output logic              io_forward_o,
    input  wire logic         type1_req_i,
    input  wire logic [7:0]   type1_bus_i,
    output logic              type1_to_link_o,
    output logic              type1_below_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]  primary_bus_reg,    primary_bus_next;
    logic [7:0]  secondary_bus_reg,  secondary_bus_next;
    logic [7:0]  subordinate_reg,    subordinate_next;
    logic [3:0]  io_bottom_reg,      io_bottom_next;
    logic [3:0]  io_top_reg,         io_top_next;
    logic [15:0] status_reg,         status_next;
    logic [7:0]  rdata_reg,          rdata_next;
    logic        rvalid_reg,         rvalid_next;
    logic        io_fwd_reg,         io_fwd_next;
    logic        t1_link_reg,        t1_link_next;
    logic        t1_below_reg,       t1_below_next;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [31:0] win_lo;
    logic [31:0] win_hi;

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = cfg_req_i.wr && cfg_req_i.addr == off;
    endfunction : wr_hit

    function automatic logic [7:0] bus_write(input logic [7:0] cur, input logic [7:0] off);
        bus_write = wr_hit(off) ? cfg_req_i.wdata : cur;
    endfunction : bus_write

    ////////////////////////////////////////////////////////////////////////////
    // Bus numbers
    always_comb begin
        primary_bus_next   = bus_write(primary_bus_reg, OFF_PRIMARY_BUS);
        secondary_bus_next = bus_write(secondary_bus_reg, OFF_SECONDARY_BUS);
        subordinate_next   = bus_write(subordinate_reg, OFF_SUBORDINATE);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            primary_bus_reg   <= RST_BUS_NUMBER;
            secondary_bus_reg <= RST_BUS_NUMBER;
            subordinate_reg   <= RST_BUS_NUMBER;
        end else begin
            primary_bus_reg   <= primary_bus_next;
            secondary_bus_reg <= secondary_bus_next;
            subordinate_reg   <= subordinate_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // I/O window fields; the low nibble is a constant and is not stored
    always_comb begin
        io_bottom_next = io_bottom_reg;
        io_top_next    = io_top_reg;
        if (wr_hit(OFF_IO_BOTTOM)) begin
            io_bottom_next = cfg_req_i.wdata[7:4];
        end
        if (wr_hit(OFF_IO_TOP)) begin
            io_top_next = cfg_req_i.wdata[7:4];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            io_bottom_reg <= RST_IO_FIELD;
            io_top_reg    <= RST_IO_FIELD;
        end else begin
            io_bottom_reg <= io_bottom_next;
            io_top_reg    <= io_top_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-side status
    always_comb begin
        set_vec                 = 16'h0000;
        set_vec[ST_POISON]      = evt_i.poisoned;
        set_vec[ST_SYS_ERR]     = evt_i.sys_err;
        set_vec[ST_UR_RECEIVED] = evt_i.ur_cpl;
        set_vec[ST_CA_RECEIVED] = evt_i.ca_cpl;
        set_vec[ST_CA_SENT]     = evt_i.ca_sent;
        set_vec[ST_MASTER_PAR]  = evt_i.master_par && parity_resp_en_i;
        clr_vec                 = 16'h0000;
        if (wr_hit(OFF_STATUS_LO)) begin
            clr_vec[7:0] = cfg_req_i.wdata;
        end
        if (wr_hit(OFF_STATUS_HI)) begin
            clr_vec[15:8] = cfg_req_i.wdata;
        end
        // Set wins over a clear in the same cycle, so no event is lost
        status_next = ((status_reg & ~clr_vec) | set_vec) & STATUS_W1C_MASK;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status_reg <= RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read return, one cycle after the request
    always_comb begin
        rvalid_next = cfg_req_i.rd;
        rdata_next  = RST_RDATA;
        if (cfg_req_i.rd) begin
            unique case (cfg_req_i.addr)
                OFF_PRIMARY_BUS:   rdata_next = primary_bus_reg;
                OFF_SECONDARY_BUS: rdata_next = secondary_bus_reg;
                OFF_SUBORDINATE:   rdata_next = subordinate_reg;
                OFF_SEC_LATENCY:   rdata_next = RST_SEC_LATENCY;
                OFF_IO_BOTTOM:     rdata_next = {io_bottom_reg, IO_ADDRESSING_TYPE};
                OFF_IO_TOP:        rdata_next = {io_top_reg, IO_ADDRESSING_TYPE};
                OFF_STATUS_LO:     rdata_next = status_reg[7:0];
                OFF_STATUS_HI:     rdata_next = status_reg[15:8];
                default:           rdata_next = RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_reg  <= RST_RDATA;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Forwarding and Type 1 decode
    always_comb begin
        win_lo        = {io_bottom_upper_i, io_bottom_reg, IO_LOW_ZEROS};
        win_hi        = {io_top_upper_i, io_top_reg, IO_LOW_ONES};
        io_fwd_next   = io_req_i && io_addr_i >= win_lo && io_addr_i <= win_hi;
        t1_link_next  = type1_req_i && type1_bus_i == secondary_bus_reg;
        t1_below_next = type1_req_i && type1_bus_i > secondary_bus_reg
                        && type1_bus_i <= subordinate_reg;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            io_fwd_reg   <= 1'b0;
            t1_link_reg  <= 1'b0;
            t1_below_reg <= 1'b0;
        end else begin
            io_fwd_reg   <= io_fwd_next;
            t1_link_reg  <= t1_link_next;
            t1_below_reg <= t1_below_next;
        end
    end

    assign cfg_rdata_o     = rdata_reg;
    assign cfg_rvalid_o    = rvalid_reg;
    assign io_forward_o    = io_fwd_reg;
    assign type1_to_link_o = t1_link_reg;
    assign type1_below_o   = t1_below_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_wr_primary;
        cfg_req_i.wr && cfg_req_i.addr == OFF_PRIMARY_BUS;
    endsequence
    sequence s_rd_primary;
        cfg_req_i.rd && cfg_req_i.addr == OFF_PRIMARY_BUS && !cfg_req_i.wr;
    endsequence
    sequence s_rd_any;
        cfg_req_i.rd;
    endsequence
    sequence s_wr_io_bottom;
        cfg_req_i.wr && cfg_req_i.addr == OFF_IO_BOTTOM;
    endsequence
    sequence s_wr_io_top;
        cfg_req_i.wr && cfg_req_i.addr == OFF_IO_TOP;
    endsequence
    sequence s_clear_poison;
        cfg_req_i.wr && cfg_req_i.addr == OFF_STATUS_HI && cfg_req_i.wdata[7];
    endsequence

    a_primary_bus_wr: assert property (
        s_wr_primary |=> primary_bus_reg == $past(cfg_req_i.wdata))
        else $error("Primary bus number not stored");
    a_primary_bus_rd: assert property (
        s_rd_primary |=> cfg_rvalid_o && cfg_rdata_o == $past(primary_bus_reg))
        else $error("Primary bus number not returned");
    a_secondary_type1: assert property (
        type1_req_i && type1_bus_i == secondary_bus_reg |=> type1_to_link_o)
        else $error("Type 1 to secondary bus not claimed");
    a_subordinate_range: assert property (
        type1_req_i && (type1_bus_i > subordinate_reg || type1_bus_i <= secondary_bus_reg)
        |=> !type1_below_o)
        else $error("Type 1 claimed outside subordinate range");
    a_latency_zero: assert property (
        cfg_req_i.rd && cfg_req_i.addr == OFF_SEC_LATENCY |=> cfg_rvalid_o && cfg_rdata_o == 8'h00)
        else $error("Latency timer not zero");
    a_io_type_nibble: assert property (
        cfg_req_i.rd && (cfg_req_i.addr == OFF_IO_BOTTOM || cfg_req_i.addr == OFF_IO_TOP)
        |=> cfg_rdata_o[3:0] == 4'h1)
        else $error("I/O type nibble not one");
    a_io_window_hit: assert property (
        io_req_i && io_addr_i == {io_bottom_upper_i, io_bottom_reg, 12'h000}
        && io_bottom_reg <= io_top_reg && io_bottom_upper_i <= io_top_upper_i
        |=> io_forward_o)
        else $error("Window bottom not inclusive");
    a_io_window_top: assert property (
        io_req_i && io_addr_i == {io_top_upper_i, io_top_reg, 12'hfff}
        && io_bottom_reg <= io_top_reg && io_bottom_upper_i <= io_top_upper_i
        |=> io_forward_o)
        else $error("Window top not inclusive");
    a_io_window_miss: assert property (
        io_req_i && io_addr_i > {io_top_upper_i, io_top_reg, 12'hfff} |=> !io_forward_o)
        else $error("Forward above window");
    a_poison_sets: assert property (
        evt_i.poisoned && !parity_resp_en_i |=> status_reg[ST_POISON])
        else $error("Poison bit not set");
    a_status_clear: assert property (
        s_clear_poison ##0 !evt_i.poisoned
        |=> !status_reg[ST_POISON])
        else $error("Write one did not clear");

    // Register access
    a_read_answered: assert property (
        s_rd_any |=> cfg_rvalid_o)
        else $error("Read not answered");
    a_no_stray_valid: assert property (
        !cfg_req_i.rd |=> !cfg_rvalid_o)
        else $error("Read valid without request");
    a_io_bottom_field: assert property (
        s_wr_io_bottom |=> io_bottom_reg == $past(cfg_req_i.wdata[7:4]))
        else $error("I/O bottom field not stored");
    a_io_top_field: assert property (
        s_wr_io_top |=> io_top_reg == $past(cfg_req_i.wdata[7:4]))
        else $error("I/O top field not stored");
    a_status_low_zero: assert property (
        cfg_req_i.rd && cfg_req_i.addr == OFF_STATUS_LO |=> cfg_rdata_o == 8'h00)
        else $error("Status low byte not zero");

    // Status events
    a_poison_enabled: assert property (
        evt_i.poisoned && parity_resp_en_i |=> status_reg[ST_POISON])
        else $error("Poison bit not set with parity enabled");
    a_set_wins_clear: assert property (
        evt_i.poisoned ##0 s_clear_poison |=> status_reg[ST_POISON])
        else $error("Clear beat a same-cycle event");
    a_poison_sticky: assert property (
        status_reg[ST_POISON]
        && !(cfg_req_i.wr && cfg_req_i.addr == OFF_STATUS_HI && cfg_req_i.wdata[7])
        |=> status_reg[ST_POISON])
        else $error("Poison bit lost without a clear");
    a_parity_gated: assert property (
        evt_i.master_par && !parity_resp_en_i && !status_reg[ST_MASTER_PAR]
        |=> !status_reg[ST_MASTER_PAR])
        else $error("Parity bit set with response disabled");
    a_parity_enabled: assert property (
        evt_i.master_par && parity_resp_en_i |=> status_reg[ST_MASTER_PAR])
        else $error("Parity bit not set with response enabled");

    // Forwarding and Type 1 decode
    a_io_below_window: assert property (
        io_req_i && io_addr_i < {io_bottom_upper_i, io_bottom_reg, IO_LOW_ZEROS}
        |=> !io_forward_o)
        else $error("Forward below window");
    a_io_upper_bits: assert property (
        io_req_i && io_addr_i[31:16] > io_top_upper_i |=> !io_forward_o)
        else $error("Upper window bits ignored");
    a_io_idle: assert property (
        !io_req_i |=> !io_forward_o)
        else $error("Forward without an I/O request");
    a_type1_below: assert property (
        type1_req_i && type1_bus_i > secondary_bus_reg && type1_bus_i <= subordinate_reg
        |=> type1_below_o)
        else $error("Type 1 below port not claimed");
    a_type1_idle: assert property (
        !type1_req_i |=> !type1_to_link_o && !type1_below_o)
        else $error("Type 1 claim without a request");
    a_type1_other_bus: assert property (
        type1_req_i && type1_bus_i != secondary_bus_reg |=> !type1_to_link_o)
        else $error("Type 1 claimed for another bus");

endmodule : dbw_regs

// file: testbench/dbw_link_model.sv
// Purpose: Link-side event source for the bridge header registers
// Assumes: Events launch just after a rising edge
// Notes:   Emits one-cycle pulses only
`timescale 1ns/1ps
module dbw_link_model
    import dbw_pkg::*;
(
    input  wire logic clk_i,
    output dbw_evt_t  evt_o
);
    initial evt_o = '0;

    task automatic send(input dbw_evt_t ev);
        @(posedge clk_i);
        #2 evt_o = ev;
        @(posedge clk_i);
        #2 evt_o = '0;
    endtask : send
endmodule : dbw_link_model

// file: testbench/downstream_bridge_bus_io_window_regs_test.sv
// Purpose: Self-checking bench for the bridge header registers
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Reads check data one cycle after the request
`timescale 1ns/1ps
module downstream_bridge_bus_io_window_regs_test
    import dbw_pkg::*;
;
    logic         clk_i, reset_i, parity_resp_en_i, io_req_i, type1_req_i;
    logic         cfg_rvalid_o, io_forward_o, type1_to_link_o, type1_below_o;
    logic [7:0]   cfg_rdata_o, type1_bus_i;
    logic [15:0]  io_bottom_upper_i, io_top_upper_i;
    logic [31:0]  io_addr_i;
    dbw_cfg_req_t cfg_req_i;
    dbw_evt_t     evt_i;
    int           miscompares, checks_done;
    logic [7:0]   rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0]   ff_tab [6]  = '{8'hff, 8'hff, 8'hff, 8'h00, 8'hf1, 8'hf1};
    logic [31:0]  io_tab [5]  = '{32'h00013000, 32'h00012fff, 32'h00015fff, 32'h00016000,
                                  32'h00023000};
    logic         io_exp [5]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0]   bus_tab [5] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09};
    logic [1:0]   t1_exp [5]  = '{2'b00, 2'b10, 2'b01, 2'b01, 2'b00};

    dbw_regs uut (.clk_i(clk_i), .reset_i(reset_i), .cfg_req_i(cfg_req_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .evt_i(evt_i),
        .parity_resp_en_i(parity_resp_en_i), .io_bottom_upper_i(io_bottom_upper_i),
        .io_top_upper_i(io_top_upper_i), .io_req_i(io_req_i), .io_addr_i(io_addr_i),
        .io_forward_o(io_forward_o), .type1_req_i(type1_req_i), .type1_bus_i(type1_bus_i),
        .type1_to_link_o(type1_to_link_o), .type1_below_o(type1_below_o));
    dbw_link_model link (.clk_i(clk_i), .evt_o(evt_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #2 cfg_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        #2 cfg_req_i = '0;
    endtask : cfg_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        #2 cfg_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        #2 cfg_req_i = '0;
        chk({7'h00, cfg_rvalid_o, cfg_rdata_o}, {8'h01, exp});
    endtask : rd_chk

    task automatic io_chk(input logic [31:0] a, input logic exp);
        @(posedge clk_i);
        #2 io_req_i = 1'b1;
        io_addr_i = a;
        @(posedge clk_i);
        #2 io_req_i = 1'b0;
        chk({15'h0000, io_forward_o}, {15'h0000, exp});
    endtask : io_chk

    task automatic t1_chk(input logic [7:0] b, input logic [1:0] exp);
        @(posedge clk_i);
        #2 type1_req_i = 1'b1;
        type1_bus_i = b;
        @(posedge clk_i);
        #2 type1_req_i = 1'b0;
        chk({14'h0000, type1_to_link_o, type1_below_o}, {14'h0000, exp});
    endtask : t1_chk

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        miscompares++;
        close_out();
    end

    initial begin
        reset_i = 1'b1;
        cfg_req_i = '0;
        parity_resp_en_i = 1'b0;
        io_req_i = 1'b0;
        io_addr_i = 32'h00000000;
        type1_req_i = 1'b0;
        type1_bus_i = 8'h00;
        io_bottom_upper_i = 16'h0001;
        io_top_upper_i = 16'h0001;
        repeat (5) @(posedge clk_i);
        #2 reset_i = 1'b0;
        for (int i = 0; i < 8; i++) rd_chk(8'h18 + i[7:0], rst_tab[i]);
        for (int i = 0; i < 6; i++) cfg_wr(8'h18 + i[7:0], 8'hff);
        for (int i = 0; i < 6; i++) rd_chk(8'h18 + i[7:0], ff_tab[i]);
        rd_chk(8'h20, 8'h00);
        cfg_wr(8'h1c, 8'h30);
        cfg_wr(8'h1d, 8'h50);
        for (int i = 0; i < 5; i++) io_chk(io_tab[i], io_exp[i]);
        cfg_wr(8'h19, 8'h05);
        cfg_wr(8'h1a, 8'h08);
        for (int i = 0; i < 5; i++) t1_chk(bus_tab[i], t1_exp[i]);
        link.send('{poisoned: 1'b1, default: 1'b0});
        link.send('{master_par: 1'b1, default: 1'b0});
        rd_chk(8'h1f, 8'h80);
        rd_chk(8'h1e, 8'h00);
        parity_resp_en_i = 1'b1;
        link.send('{master_par: 1'b1, default: 1'b0});
        link.send('{sys_err: 1'b1, ur_cpl: 1'b1, ca_cpl: 1'b1, ca_sent: 1'b1, default: 1'b0});
        rd_chk(8'h1f, 8'hf9);
        rd_chk(8'h1e, 8'h00);
        cfg_wr(8'h1f, 8'h80);
        cfg_wr(8'h1e, 8'hff);
        rd_chk(8'h1f, 8'h79);
        rd_chk(8'h1e, 8'h00);
        @(posedge clk_i);
        #2 reset_i = 1'b1;
        @(posedge clk_i);
        #2 reset_i = 1'b0;
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h1f, 8'h00);
        fork
            link.send('{poisoned: 1'b1, default: 1'b0});
            cfg_wr(8'h1f, 8'h80);
        join
        rd_chk(8'h1f, 8'h80);
        close_out();
    end
endmodule : downstream_bridge_bus_io_window_regs_test
